// ### inc/swn_map.svh
// Register numbers, field positions, reset values and fixed figures of the node registers.
`ifndef SWN_MAP_SVH
`define SWN_MAP_SVH

`define SWN_REG_DESC        8'h01
`define SWN_REG_SEC         8'h04
`define SWN_REG_NODE        8'h05
`define SWN_REG_PLL         8'h06
`define SWN_REG_SWDIV       8'h07
`define SWN_REG_REFDIV      8'h08
`define SWN_REG_DIRLO       8'h0c
`define SWN_REG_DIRHI       8'h0d
`define SWN_REG_DBGCFG      8'h10
`define SWN_REG_DBGSRC      8'h1f

`define SWN_SEC_WLOCK_BIT   31
`define SWN_SEC_PLLLOCK_BIT 8
`define SWN_SEC_HDR_BIT     0
`define SWN_SEC_MASK        32'h8000_0101

`define SWN_PLL_MASK        32'h039f_ff7f
`define SWN_DIV_MASK        32'h0000_ffff
`define SWN_DBGCFG_MASK     32'h0000_0003
`define SWN_DBGSRC_MASK     32'h0000_0011

`define SWN_DBG_CALL_BIT    1
`define SWN_DBG_PULL_BIT    0
`define SWN_SRC_PIN_BIT     4
`define SWN_SRC_TILE_BIT    0

`define SWN_SWDIV_RST       16'h0000
`define SWN_REFDIV_RST      16'h0003

// Switch description contents; plain defaults for this build.
`define SWN_NUM_LINKS       8'h08
`define SWN_NUM_CORES       8'h01
`define SWN_LINKS_PER_PROC  8'h04

// PLL presets chosen by the two boot strap pins; plain defaults.
`define SWN_PLL_STRAP0      32'h0080_6301
`define SWN_PLL_STRAP1      32'h0080_3101
`define SWN_PLL_STRAP2      32'h0100_6301
`define SWN_PLL_STRAP3      32'h0100_3101

`endif

// ### inc/swn_pkg.sv
// Types shared by the node configuration block.
package swn_pkg;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } swn_cfg_req_s;

    typedef struct packed {
        logic        valid;
        logic        ok;
        logic [31:0] rdata;
    } swn_cfg_rsp_s;

    typedef struct packed {
        logic        valid;
        logic [15:0] dest;
    } swn_route_req_s;

    typedef struct packed {
        logic        valid;
        logic        deliver_local;
        logic [3:0]  dir;
    } swn_route_rsp_s;

    typedef enum logic {
        SWN_BOOT_LOAD = 1'b0,
        SWN_BOOT_RUN  = 1'b1
    } swn_boot_e;

endpackage

// ### rtl/swn_clk_div.sv
// Programmable divider giving a one-cycle enable every divider-plus-one cycles.
module swn_clk_div (
    // Clock and reset
    input  wire logic        clk_sys_in,
    input  wire logic        sys_rst_in,
    // Divider value
    input  wire logic [15:0] div_in,
    // Enable pulse
    output logic             tick_out
);

    logic [15:0] count_r;
    logic [15:0] count_nxt;
    logic        tick_nxt;

    always_comb begin
        tick_nxt  = (count_r >= div_in);
        count_nxt = tick_nxt ? 16'h0000 : 16'(count_r + 16'h0001);
    end

    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            count_r  <= 16'h0000;
            tick_out <= 1'b0;
        end else begin
            count_r  <= count_nxt;
            tick_out <= tick_nxt;
        end
    end

    // A nonzero divider never gives two pulses in a row.
    div_spacing_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
        (tick_out && div_in != 16'h0000 && $stable(div_in)) |=> !tick_out)
        else $error("divider pulsed twice in a row");

endmodule // swn_clk_div

// ### rtl/swn_route_lookup.sv
// Picks the direction from the most significant bit where destination and node differ.
module swn_route_lookup (
    // Identifiers
    input  wire logic [15:0] node_id_in,
    input  wire logic [15:0] dest_in,
    // Direction tables, bit 15 entry on top
    input  wire logic [63:0] dirs_in,
    // Result
    output logic             deliver_local_out,
    output logic [3:0]       dir_out
);

    // The ascending scan lets the highest mismatch win.
    always_comb begin
        deliver_local_out = 1'b1;
        dir_out           = 4'h0;
        for (int i = 0; i < 16; i++) begin
            if (node_id_in[i] != dest_in[i]) begin
                deliver_local_out = 1'b0;
                dir_out           = dirs_in[i*4 +: 4];
            end
        end
    end

endmodule // swn_route_lookup

// ### rtl/swn_config_regs.sv
// Configuration and status registers of a message-switch node.
//
// Operation
// - Description register is read-only: link count, core count, links per processor.
// - Global write-lock bit set rejects every configuration register write.
// - PLL lock bit set ignores any PLL settings update.
// - Header-mode bit selects one-byte headers; all nodes must match.
// - Writable 16-bit node identifier, reset zero, compared from most significant bit.
// - Any accepted write to PLL settings resets the attached processor tile.
// - PLL divider and multiplier fields writable; reset values from boot strap pins.
// - Switch clock is PLL clock divided by divider plus one; resets zero.
// - Reference clock is PLL clock divided by divider plus one; resets three.
// - Low direction register holds entries for identifier bits 7 down to 0.
// - High direction register holds entries for identifier bits 15 down to 8.
// - Mismatching packets go in the direction of the highest differing bit.
// - Debug-call enable lets debug pin activity raise a debug call trap.
// - Pull-down enable drives the debug wire low while in debug mode.
// - Pin-source flag set when the debug pin caused the latest debug interrupt.
// - Tile-source flag set when the local tile caused the latest debug interrupt.
// - All registers reachable by configuration reads and writes to this node.
`include "swn_map.svh"

module swn_config_regs
    import swn_pkg::*;
(
    // Clock and reset
    input  wire logic           clk_sys_in,
    input  wire logic           sys_rst_in,
    // Configuration access
    input  wire swn_cfg_req_s   cfg_req_in,
    output swn_cfg_rsp_s        cfg_rsp_out,
    // Boot straps
    input  wire logic           boot_strap_pin_0_in,
    input  wire logic           boot_strap_pin_1_in,
    // Routing lookup
    input  wire swn_route_req_s route_req_in,
    output swn_route_rsp_s      route_rsp_out,
    // Clocking and node mode
    output logic [31:0]         pll_settings_out,
    output logic                tile_reset_out,
    output logic                switch_clk_en_out,
    output logic                ref_clk_en_out,
    output logic                header_one_byte_out,
    // Debug
    input  wire logic           debug_req_n_in,
    input  wire logic           debug_mode_in,
    input  wire logic           tile_debug_event_in,
    output logic                debug_call_trap_out,
    output logic                debug_req_n_out,
    output logic                debug_req_n_oe_out
);

    swn_boot_e      boot_r;
    swn_boot_e      boot_nxt;
    logic [31:0]    sec_r;
    logic [31:0]    sec_nxt;
    logic [15:0]    node_r;
    logic [15:0]    node_nxt;
    logic [31:0]    pll_r;
    logic [31:0]    pll_nxt;
    logic [15:0]    swdiv_r;
    logic [15:0]    swdiv_nxt;
    logic [15:0]    refdiv_r;
    logic [15:0]    refdiv_nxt;
    logic [31:0]    dirlo_r;
    logic [31:0]    dirlo_nxt;
    logic [31:0]    dirhi_r;
    logic [31:0]    dirhi_nxt;
    logic [31:0]    dbgcfg_r;
    logic [31:0]    dbgcfg_nxt;
    logic [31:0]    dbgsrc_r;
    logic [31:0]    dbgsrc_nxt;
    logic           tile_rst_nxt;
    logic           pin_prev_r;
    logic           trap_nxt;
    logic           oe_nxt;
    swn_cfg_rsp_s   rsp_nxt;
    swn_route_rsp_s route_nxt;
    logic [31:0]    strap_word;
    logic [31:0]    rd_word;
    logic           rd_hit;
    logic           wr;
    logic           wr_ok;
    logic           pll_wr_ok;
    logic           pin_event;
    logic           lk_local;
    logic [3:0]     lk_dir;

    assign wr        = cfg_req_in.valid && cfg_req_in.write;
    assign wr_ok     = wr && !sec_r[`SWN_SEC_WLOCK_BIT];
    assign pll_wr_ok = wr_ok && (cfg_req_in.addr == `SWN_REG_PLL)
                       && !sec_r[`SWN_SEC_PLLLOCK_BIT];
    assign pin_event = pin_prev_r && !debug_req_n_in && dbgcfg_r[`SWN_DBG_CALL_BIT];

    always_comb begin
        unique case ({boot_strap_pin_1_in, boot_strap_pin_0_in})
            2'b00: strap_word = `SWN_PLL_STRAP0;
            2'b01: strap_word = `SWN_PLL_STRAP1;
            2'b10: strap_word = `SWN_PLL_STRAP2;
            2'b11: strap_word = `SWN_PLL_STRAP3;
        endcase
    end

    always_comb begin
        rd_hit  = 1'b1;
        rd_word = 32'h0000_0000;
        case (cfg_req_in.addr)
            `SWN_REG_DESC:   rd_word = {8'h00, `SWN_NUM_LINKS, `SWN_NUM_CORES,
                                        `SWN_LINKS_PER_PROC};
            `SWN_REG_SEC:    rd_word = sec_r & `SWN_SEC_MASK;
            `SWN_REG_NODE:   rd_word = {16'h0000, node_r};
            `SWN_REG_PLL:    rd_word = pll_r & `SWN_PLL_MASK;
            `SWN_REG_SWDIV:  rd_word = {16'h0000, swdiv_r};
            `SWN_REG_REFDIV: rd_word = {16'h0000, refdiv_r};
            `SWN_REG_DIRLO:  rd_word = dirlo_r;
            `SWN_REG_DIRHI:  rd_word = dirhi_r;
            `SWN_REG_DBGCFG: rd_word = dbgcfg_r & `SWN_DBGCFG_MASK;
            `SWN_REG_DBGSRC: rd_word = dbgsrc_r & `SWN_DBGSRC_MASK;
            default:         rd_hit  = 1'b0;
        endcase
    end

    // Next values of the register file, the answer and the debug logic.
    always_comb begin
        boot_nxt     = boot_r;
        sec_nxt      = sec_r;
        node_nxt     = node_r;
        pll_nxt      = pll_r;
        swdiv_nxt    = swdiv_r;
        refdiv_nxt   = refdiv_r;
        dirlo_nxt    = dirlo_r;
        dirhi_nxt    = dirhi_r;
        dbgcfg_nxt   = dbgcfg_r;
        dbgsrc_nxt   = dbgsrc_r;
        tile_rst_nxt = 1'b0;

        rsp_nxt.valid = cfg_req_in.valid;
        rsp_nxt.ok    = cfg_req_in.valid && rd_hit && !(wr && !wr_ok)
                        && !(wr_ok && cfg_req_in.addr == `SWN_REG_PLL && !pll_wr_ok);
        rsp_nxt.rdata = (cfg_req_in.valid && !cfg_req_in.write) ? rd_word : 32'h0000_0000;

        if (wr_ok) begin
            case (cfg_req_in.addr)
                `SWN_REG_SEC:    sec_nxt    = cfg_req_in.wdata & `SWN_SEC_MASK;
                `SWN_REG_NODE:   node_nxt   = cfg_req_in.wdata[15:0];
                `SWN_REG_SWDIV:  swdiv_nxt  = cfg_req_in.wdata[15:0];
                `SWN_REG_REFDIV: refdiv_nxt = cfg_req_in.wdata[15:0];
                `SWN_REG_DIRLO:  dirlo_nxt  = cfg_req_in.wdata;
                `SWN_REG_DIRHI:  dirhi_nxt  = cfg_req_in.wdata;
                `SWN_REG_DBGCFG: dbgcfg_nxt = cfg_req_in.wdata & `SWN_DBGCFG_MASK;
                `SWN_REG_DBGSRC: dbgsrc_nxt = cfg_req_in.wdata & `SWN_DBGSRC_MASK;
                default:         ;
            endcase
        end

        if (pll_wr_ok) begin
            pll_nxt      = cfg_req_in.wdata & `SWN_PLL_MASK;
            tile_rst_nxt = 1'b1;
        end

        // The strap preset is taken once, in the first cycle after reset release.
        if (boot_r == SWN_BOOT_LOAD) begin
            pll_nxt  = strap_word & `SWN_PLL_MASK;
            boot_nxt = SWN_BOOT_RUN;
        end

        // Hardware events win over a software write of the source flags.
        if (pin_event || tile_debug_event_in) begin
            dbgsrc_nxt[`SWN_SRC_PIN_BIT]  = pin_event;
            dbgsrc_nxt[`SWN_SRC_TILE_BIT] = tile_debug_event_in;
        end

        trap_nxt = pin_event;
        oe_nxt   = dbgcfg_r[`SWN_DBG_PULL_BIT] && debug_mode_in;

        route_nxt.valid         = route_req_in.valid;
        route_nxt.deliver_local = route_req_in.valid && lk_local;
        route_nxt.dir           = (route_req_in.valid && !lk_local) ? lk_dir : 4'h0;
    end

    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            boot_r              <= SWN_BOOT_LOAD;
            sec_r               <= 32'h0000_0000;
            node_r              <= 16'h0000;
            pll_r               <= 32'h0000_0000;
            swdiv_r             <= `SWN_SWDIV_RST;
            refdiv_r            <= `SWN_REFDIV_RST;
            dirlo_r             <= 32'h0000_0000;
            dirhi_r             <= 32'h0000_0000;
            dbgcfg_r            <= 32'h0000_0000;
            dbgsrc_r            <= 32'h0000_0000;
            tile_reset_out      <= 1'b0;
            pin_prev_r          <= 1'b1;
            debug_call_trap_out <= 1'b0;
            debug_req_n_oe_out  <= 1'b0;
            cfg_rsp_out         <= '0;
            route_rsp_out       <= '0;
        end else begin
            boot_r              <= boot_nxt;
            sec_r               <= sec_nxt;
            node_r              <= node_nxt;
            pll_r               <= pll_nxt;
            swdiv_r             <= swdiv_nxt;
            refdiv_r            <= refdiv_nxt;
            dirlo_r             <= dirlo_nxt;
            dirhi_r             <= dirhi_nxt;
            dbgcfg_r            <= dbgcfg_nxt;
            dbgsrc_r            <= dbgsrc_nxt;
            tile_reset_out      <= tile_rst_nxt;
            pin_prev_r          <= debug_req_n_in;
            debug_call_trap_out <= trap_nxt;
            debug_req_n_oe_out  <= oe_nxt;
            cfg_rsp_out         <= rsp_nxt;
            route_rsp_out       <= route_nxt;
        end
    end

    assign pll_settings_out    = pll_r;
    assign header_one_byte_out = sec_r[`SWN_SEC_HDR_BIT];
    // The debug wire is only ever pulled low; the enable does the work.
    assign debug_req_n_out     = 1'b0;

    swn_route_lookup u_lookup (
        .node_id_in        (node_r),
        .dest_in           (route_req_in.dest),
        .dirs_in           ({dirhi_r, dirlo_r}),
        .deliver_local_out (lk_local),
        .dir_out           (lk_dir)
    );

    swn_clk_div u_swdiv (
        .clk_sys_in (clk_sys_in),
        .sys_rst_in (sys_rst_in),
        .div_in     (swdiv_r),
        .tick_out   (switch_clk_en_out)
    );

    swn_clk_div u_refdiv (
        .clk_sys_in (clk_sys_in),
        .sys_rst_in (sys_rst_in),
        .div_in     (refdiv_r),
        .tick_out   (ref_clk_en_out)
    );

    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (sys_rst_in);

    wlock_reject_a: assert property (
        (wr && sec_r[`SWN_SEC_WLOCK_BIT])
        |=> (cfg_rsp_out.valid && !cfg_rsp_out.ok && $stable(node_r) && $stable(dirlo_r)))
        else $error("write accepted while write lock set");

    pll_lock_hold_a: assert property (
        (wr_ok && cfg_req_in.addr == `SWN_REG_PLL && sec_r[`SWN_SEC_PLLLOCK_BIT]
         && boot_r == SWN_BOOT_RUN)
        |=> ($stable(pll_r) && !tile_reset_out && !cfg_rsp_out.ok))
        else $error("PLL settings changed while locked");

    tile_reset_pulse_a: assert property (
        (pll_wr_ok && boot_r == SWN_BOOT_RUN)
        |=> (tile_reset_out && pll_r == ($past(cfg_req_in.wdata) & `SWN_PLL_MASK))
        ##1 (!tile_reset_out || $past(pll_wr_ok)))
        else $error("PLL write did not pulse tile reset once");

    header_mode_a: assert property (
        (wr_ok && cfg_req_in.addr == `SWN_REG_SEC)
        |=> header_one_byte_out == $past(cfg_req_in.wdata[`SWN_SEC_HDR_BIT]))
        else $error("header mode not taken from write");

    node_id_write_a: assert property (
        (wr_ok && cfg_req_in.addr == `SWN_REG_NODE)
        |=> node_r == $past(cfg_req_in.wdata[15:0]))
        else $error("node identifier not updated");

    desc_read_a: assert property (
        (cfg_req_in.valid && !cfg_req_in.write && cfg_req_in.addr == `SWN_REG_DESC)
        |=> (cfg_rsp_out.ok && cfg_rsp_out.rdata ==
             {8'h00, `SWN_NUM_LINKS, `SWN_NUM_CORES, `SWN_LINKS_PER_PROC}))
        else $error("switch description read wrong");

    route_local_a: assert property (
        (route_req_in.valid && route_req_in.dest == node_r)
        |=> (route_rsp_out.valid && route_rsp_out.deliver_local && route_rsp_out.dir == 4'h0))
        else $error("matching packet not delivered locally");

    route_top_bit_a: assert property (
        (route_req_in.valid && route_req_in.dest[15] != node_r[15])
        |=> (!route_rsp_out.deliver_local && route_rsp_out.dir == $past(dirhi_r[31:28])))
        else $error("top mismatch did not pick bit 15 entry");

    debug_trap_a: assert property (
        (pin_prev_r && !debug_req_n_in && dbgcfg_r[`SWN_DBG_CALL_BIT])
        |=> (debug_call_trap_out && dbgsrc_r[`SWN_SRC_PIN_BIT]))
        else $error("debug pin did not raise trap");

    tile_source_a: assert property (
        (tile_debug_event_in && !pin_event) |=> (dbgsrc_r[`SWN_SRC_TILE_BIT]
        && !dbgsrc_r[`SWN_SRC_PIN_BIT]))
        else $error("tile debug source not recorded");

    pull_down_a: assert property (
        (dbgcfg_r[`SWN_DBG_PULL_BIT] && debug_mode_in) |=> debug_req_n_oe_out)
        else $error("debug wire not pulled low in debug mode");

    reserved_zero_a: assert property (
        (cfg_req_in.valid && !cfg_req_in.write && cfg_req_in.addr == `SWN_REG_DBGCFG)
        |=> cfg_rsp_out.rdata[31:2] == 30'h0000_0000)
        else $error("reserved bits read nonzero");

endmodule // swn_config_regs

// ### testbench/swn_cfg_host.sv
// Remote node model that issues configuration reads and writes to the node.
module swn_cfg_host
    import swn_pkg::*;
(
    // Clock
    input  wire logic         clk_sys_in,
    // Configuration access
    output swn_cfg_req_s      cfg_req_out,
    input  wire swn_cfg_rsp_s cfg_rsp_in
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        cfg_req_out = '0;
    end

    task automatic access(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
                          output logic ok, output logic [31:0] rdata);
        int i;
        ok = 1'bx;
        rdata = 'x;
        @(negedge clk_sys_in);
        cfg_req_out = '{valid: 1'b1, write: wr, addr: addr, wdata: wdata};
        @(negedge clk_sys_in);
        // Released lines show the inverse so stale values are never read as good.
        cfg_req_out = '{valid: 1'b0, write: ~wr, addr: ~addr, wdata: ~wdata};
        for (i = 0; i < 3; i++) begin
            if (cfg_rsp_in.valid === 1'b1) begin
                ok = cfg_rsp_in.ok;
                rdata = cfg_rsp_in.rdata;
                break;
            end
            @(negedge clk_sys_in);
        end
    endtask
endmodule // swn_cfg_host

// ### testbench/switch_node_config_regs_bench.sv
// Self-checking bench of the node configuration registers.
`include "swn_map.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_fail++; \
    $display("unexpected at %0t: got %0h expected %0h", $time, g, e); end end

module switch_node_config_regs_bench
    import swn_pkg::*;
();
    timeunit 1ns;
    timeprecision 100ps;

    localparam logic [31:0] DESC = {8'h00, `SWN_NUM_LINKS, `SWN_NUM_CORES, `SWN_LINKS_PER_PROC};
    localparam logic [31:0] PLL0 = `SWN_PLL_STRAP2 & `SWN_PLL_MASK;
    localparam logic [7:0]  RA [9] = '{`SWN_REG_DESC, `SWN_REG_NODE, `SWN_REG_PLL,
        `SWN_REG_SWDIV, `SWN_REG_REFDIV, `SWN_REG_DIRLO, `SWN_REG_DIRHI, `SWN_REG_DBGCFG,
        `SWN_REG_DBGSRC};
    localparam logic [31:0] RRST [8] = '{DESC, 32'h0, PLL0, 32'h0, 32'h3, 32'h0, 32'h0, 32'h0};
    localparam logic [31:0] RONE [9] = '{DESC, 32'hffff, `SWN_PLL_MASK, 32'hffff, 32'hffff,
        32'hffff_ffff, 32'hffff_ffff, `SWN_DBGCFG_MASK, `SWN_DBGSRC_MASK};

    logic           clk;
    logic           rst;
    swn_cfg_req_s   cfg_req;
    swn_cfg_rsp_s   cfg_rsp;
    swn_route_req_s route_req;
    swn_route_rsp_s route_rsp;
    logic [31:0]    pll;
    logic           tile_rst;
    logic           sw_tick;
    logic           ref_tick;
    logic           hdr;
    wire logic      dbg_in;
    logic           dbg_mode;
    logic           tile_evt;
    logic           trap;
    logic           dbg_out;
    logic           dbg_oe;
    logic           ext_low;
    int             n_fail;
    int             comparisons;
    int             n_tile;
    int             n_trap;

    swn_config_regs u_swn_config_regs (
        .clk_sys_in(clk), .sys_rst_in(rst), .cfg_req_in(cfg_req), .cfg_rsp_out(cfg_rsp),
        .boot_strap_pin_0_in(1'b0), .boot_strap_pin_1_in(1'b1),
        .route_req_in(route_req), .route_rsp_out(route_rsp),
        .pll_settings_out(pll), .tile_reset_out(tile_rst), .switch_clk_en_out(sw_tick),
        .ref_clk_en_out(ref_tick), .header_one_byte_out(hdr),
        .debug_req_n_in(dbg_in), .debug_mode_in(dbg_mode), .tile_debug_event_in(tile_evt),
        .debug_call_trap_out(trap), .debug_req_n_out(dbg_out), .debug_req_n_oe_out(dbg_oe)
    );

    swn_cfg_host u_swn_cfg_host (
        .clk_sys_in(clk), .cfg_req_out(cfg_req), .cfg_rsp_in(cfg_rsp)
    );

    // The debug wire has a pull-up; either party may pull it low.
    assign dbg_in = ((dbg_oe === 1'b1 && dbg_out === 1'b0) || ext_low) ? 1'b0 : 1'b1;

    always #2.5 clk = ~clk;

    // Pulses are counted on the falling edge, where they have settled.
    always @(negedge clk) begin
        if (tile_rst === 1'b1) n_tile++;
        if (trap === 1'b1) n_trap++;
    end

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic eok);
        logic        ok;
        logic [31:0] r;
        u_swn_cfg_host.access(1'b1, a, d, ok, r);
        `CHK(ok, eok)
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic eok);
        logic        ok;
        logic [31:0] r;
        u_swn_cfg_host.access(1'b0, a, 32'h0, ok, r);
        `CHK(ok, eok)
        `CHK(r, e)
    endtask

    task automatic route(input logic [15:0] dst, input logic el, input logic [3:0] ed);
        int i;
        @(negedge clk);
        route_req = '{valid: 1'b1, dest: dst};
        @(negedge clk);
        route_req = '{valid: 1'b0, dest: ~dst};
        for (i = 0; i < 3 && route_rsp.valid !== 1'b1; i++) @(negedge clk);
        `CHK(route_rsp.valid, 1'b1)
        `CHK(route_rsp.deliver_local, el)
        `CHK(route_rsp.dir, ed)
    endtask

    // Counts cycles between two consecutive enable pulses of one divider.
    task automatic period(input logic sel, output int n);
        int i;
        n = 0;
        for (i = 0; i < 100 && (sel ? ref_tick : sw_tick) !== 1'b1; i++) @(negedge clk);
        do begin
            @(negedge clk);
            n++;
        end while ((sel ? ref_tick : sw_tick) !== 1'b1 && n < 100);
    endtask

    task automatic pin_pulse();
        @(negedge clk);
        ext_low = 1'b1;
        repeat (3) @(negedge clk);
        ext_low = 1'b0;
        repeat (3) @(negedge clk);
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        $display("unexpected at %0t: watchdog expired", $time);
        close_out();
    end

    initial begin
        int          n;
        logic [15:0] d;
        clk = 1'b0;
        rst = 1'b1;
        route_req = '0;
        dbg_mode = 1'b0;
        tile_evt = 1'b0;
        ext_low = 1'b0;
        repeat (8) @(negedge clk);
        rst = 1'b0;
        repeat (2) @(negedge clk);
        for (int i = 0; i < 8; i++) rd(RA[i], RRST[i], 1'b1);
        rd(`SWN_REG_SEC, 32'h0, 1'b1);
        `CHK(pll, PLL0)
        rd(8'h02, 32'h0, 1'b0);
        n = n_tile;
        for (int i = 0; i < 9; i++) begin
            wr(RA[i], 32'hffff_ffff, 1'b1);
            rd(RA[i], RONE[i], 1'b1);
        end
        `CHK(n_tile, n + 1)
        wr(`SWN_REG_DBGCFG, 32'h0, 1'b1);
        wr(`SWN_REG_SWDIV, 32'h2, 1'b1);
        period(1'b0, n);
        `CHK(n, 3)
        wr(`SWN_REG_REFDIV, 32'h4, 1'b1);
        period(1'b1, n);
        `CHK(n, 5)
        wr(`SWN_REG_NODE, 32'ha5c3, 1'b1);
        wr(`SWN_REG_DIRLO, 32'h7654_3210, 1'b1);
        wr(`SWN_REG_DIRHI, 32'hfedc_ba98, 1'b1);
        for (int i = 0; i < 16; i++) begin
            d = 16'ha5c3 ^ ((16'h1 << i) | ((16'h1 << i) - 16'h1));
            route(d, 1'b0, 4'(i));
        end
        route(16'ha5c3, 1'b1, 4'h0);
        wr(`SWN_REG_DBGCFG, 32'h2, 1'b1);
        n = n_trap;
        pin_pulse();
        `CHK(n_trap, n + 1)
        rd(`SWN_REG_DBGSRC, 32'h10, 1'b1);
        @(negedge clk);
        tile_evt = 1'b1;
        @(negedge clk);
        tile_evt = 1'b0;
        rd(`SWN_REG_DBGSRC, 32'h01, 1'b1);
        wr(`SWN_REG_DBGCFG, 32'h1, 1'b1);
        pin_pulse();
        `CHK(n_trap, n + 1)
        dbg_mode = 1'b1;
        repeat (3) @(negedge clk);
        `CHK(dbg_oe, 1'b1)
        `CHK(dbg_in, 1'b0)
        dbg_mode = 1'b0;
        repeat (3) @(negedge clk);
        `CHK(dbg_oe, 1'b0)
        wr(`SWN_REG_SEC, 32'h100, 1'b1);
        n = n_tile;
        wr(`SWN_REG_PLL, 32'h0, 1'b0);
        rd(`SWN_REG_PLL, `SWN_PLL_MASK, 1'b1);
        `CHK(n_tile, n)
        wr(`SWN_REG_SEC, 32'h101, 1'b1);
        `CHK(hdr, 1'b1)
        wr(`SWN_REG_SEC, 32'h8000_0101, 1'b1);
        wr(`SWN_REG_NODE, 32'h1234, 1'b0);
        rd(`SWN_REG_NODE, 32'ha5c3, 1'b1);
        wr(`SWN_REG_SEC, 32'h0, 1'b0);
        `CHK(hdr, 1'b1)
        // A second reset in mid-run must clear the write lock and header mode and restore the identifier and the preset.
        @(negedge clk);
        rst = 1'b1;
        repeat (8) @(negedge clk);
        rst = 1'b0;
        repeat (2) @(negedge clk);
        `CHK(hdr, 1'b0)
        `CHK(pll, PLL0)
        rd(`SWN_REG_NODE, 32'h0, 1'b1);
        wr(`SWN_REG_NODE, 32'h1234, 1'b1);
        rd(`SWN_REG_NODE, 32'h1234, 1'b1);
        close_out();
    end
endmodule // switch_node_config_regs_bench
